/* File: dv/glc_line_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "glc_regs.svh"
module glc_line_asserts
  import glc_pkg::*;
#(
  parameter logic [`GLC_CNT_W-1:0] IFC_CYCLES = `GLC_IFC_CYCLES
) (
  // Clock, reset, register port
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [`GLC_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Bus side
  input wire logic dav_n_in,
  input wire logic [7:0] dio_n_in,
  input wire logic ifc_n_oe_out,
  input wire logic ren_n_oe_out,
  input wire logic atn_n_oe_out,
  input wire logic eoi_n_oe_out,
  input wire logic nrfd_n_oe_out,
  input wire logic control_taken_out,
  input wire logic parallel_poll_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic [`GLC_CNT_W-1:0] ifc_len;
  logic ctl_wr;
  // Soft reinitialise writes ignore every other bit
  assign ctl_wr = wr_in && addr_in == `GLC_OFS_CTRL && !wdata_in[6];
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) ifc_len <= `GLC_CNT_ZERO;
    else ifc_len <= ifc_n_oe_out ? ifc_len + `GLC_CNT_ONE : `GLC_CNT_ZERO;
  end
  sequence s_hold_released;
    nrfd_n_oe_out && dav_n_in && !wr_in;
  endsequence
  sequence s_atn_taken;
    atn_n_oe_out && !nrfd_n_oe_out;
  endsequence
  a_ifc_start: assert property (ctl_wr && wdata_in[0] |=> ifc_n_oe_out)
    else $error("IFC not driven after write");
  a_ifc_len: assert property ($fell(ifc_n_oe_out) |-> ifc_len == IFC_CYCLES)
    else $error("IFC pulse length wrong");
  a_ifc_bound: assert property (ifc_len <= IFC_CYCLES)
    else $error("IFC pulse too long");
  a_ren_follow: assert property (ctl_wr
    |=> ren_n_oe_out == $past(wdata_in[1])) else $error("REN wrong");
  a_atn_direct: assert property (ctl_wr && wdata_in[3] |=> atn_n_oe_out)
    else $error("ATN not driven at once");
  a_reinit_clear: assert property (wr_in && addr_in == `GLC_OFS_CTRL
    && wdata_in[6] |=> !(ren_n_oe_out || atn_n_oe_out || ifc_n_oe_out
    || eoi_n_oe_out || nrfd_n_oe_out)) else $error("Reinit left lines");
  a_take_after: assert property (s_hold_released |=> s_atn_taken)
    else $error("Take-over did not set ATN");
  a_nrfd_keep: assert property ($fell(nrfd_n_oe_out) && !$past(wr_in)
    |-> atn_n_oe_out) else $error("NRFD dropped before ATN");
  a_taken_pulse: assert property (control_taken_out
    |-> atn_n_oe_out ##1 !control_taken_out) else $error("Taken pulse bad");
  a_ppoll_level: assert property (parallel_poll_out
    == (atn_n_oe_out && eoi_n_oe_out)) else $error("Poll level wrong");
  a_poll_read: assert property (rd_in && addr_in == `GLC_OFS_POLL
    |=> rdata_out == ~$past(dio_n_in)) else $error("Poll data wrong");
endmodule : glc_line_asserts
bind glc_line_control glc_line_asserts #(.IFC_CYCLES(IFC_CYCLES))
  glc_line_asserts_inst (.*);
`default_nettype wire

/* File: dv/glc_line_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "glc_regs.svh"
module glc_line_control_tb_top
  import glc_pkg::*;
;
  localparam int IFC_N = 8;
  logic clock_in, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic send = 1'b0, eoi = 1'b0, dav_n_in, talker_eoi_n;
  logic [3:0] addr_in = 4'h0, hold = 4'h0;
  logic [7:0] wdata_in = 8'h00, dio_n_in = 8'hff, v, rdata_out;
  logic ifc_n_out, ren_n_out, atn_n_out, eoi_n_out, nrfd_n_out;
  logic ifc_n_oe_out, ren_n_oe_out, atn_n_oe_out, eoi_n_oe_out, nrfd_n_oe_out;
  logic listen_unconditional_out, control_taken_out, parallel_poll_out;
  int mismatches = 0, n_checks = 0, i;
  // Lines are wired-AND with pull-ups; the talker shares EOI
  glc_line_control #(.IFC_CYCLES(IFC_N)) glc_line_control_inst (
    .*, .ce_in(1'b1), .ndac_n_in(1'b1), .srq_n_in(1'b1),
    .ifc_n_in(!ifc_n_oe_out), .ren_n_in(!ren_n_oe_out),
    .atn_n_in(!atn_n_oe_out), .nrfd_n_in(!nrfd_n_oe_out),
    .eoi_n_in(talker_eoi_n && !eoi_n_oe_out));
  glc_talker_model glc_talker_model_inst (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .send_in(send), .hold_in(hold), .eoi_in(eoi),
    .dav_n_out(dav_n_in), .eoi_n_out(talker_eoi_n));
  task automatic chk(input string what, input logic [8:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A wait that runs out ends the run at once
  task automatic expire(input logic ok);
    if (!ok) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    q = rdata_out;
  endtask
  task automatic talk(input logic [3:0] h, input logic e);
    @(posedge clock_in);
    send <= 1'b1;
    hold <= h;
    eoi <= e;
    @(posedge clock_in);
    send <= 1'b0;
  endtask
  task automatic t_ifc;
    wr(`GLC_OFS_CTRL, 8'h01);
    wr(`GLC_OFS_CTRL, 8'h01);
    @(negedge clock_in);
    for (i = 0; i < 40 && ifc_n_oe_out === 1'b1; i++) @(negedge clock_in);
    expire(i < 40);
    chk("ifc cycles", 9'(i), 9'(IFC_N - 2));
  endtask
  task automatic t_ren;
    logic [7:0] d[4] = '{8'h02, 8'h00, 8'h02, 8'h42};
    for (int k = 0; k < 4; k++) begin
      wr(`GLC_OFS_CTRL, d[k]);
      @(negedge clock_in);
      chk("ren", ren_n_oe_out, !k[0]);
    end
  endtask
  task automatic t_atn;
    talk(4'h8, 1'b0);
    wr(`GLC_OFS_CTRL, 8'h08);
    @(negedge clock_in);
    chk("atn mid byte", {dav_n_in, atn_n_oe_out}, 9'h001);
    wr(`GLC_OFS_CTRL, 8'h00);
    repeat (8) @(posedge clock_in);
  endtask
  task automatic t_tcs;
    wr(`GLC_OFS_CTRL, 8'h10);
    repeat (20) @(negedge clock_in);
    chk("no byte", {atn_n_oe_out, nrfd_n_oe_out}, 9'h000);
    talk(4'h4, 1'b0);
    repeat (2) @(negedge clock_in);
    chk("nrfd hold", nrfd_n_oe_out, 9'h001);
    for (i = 0; i < 40 && control_taken_out !== 1'b1; i++) @(negedge clock_in);
    expire(i < 40);
    chk("taken", {atn_n_oe_out, nrfd_n_oe_out}, 9'h002);
    rd(`GLC_OFS_CTRL, v);
    chk("tcs cleared", v[4], 9'h000);
  endtask
  task automatic t_end;
    logic [7:0] d[3] = '{8'h88, 8'h80, 8'h80};
    for (int k = 0; k < 3; k++) begin
      wr(`GLC_OFS_CTRL, d[k]);
      if (k < 2) talk(4'h2, 1'b1);
      repeat (4) @(posedge clock_in);
      rd(`GLC_OFS_STAT, v);
      chk("end seen", v[0], k == 1);
    end
  endtask
  task automatic t_poll;
    @(posedge clock_in);
    dio_n_in <= 8'hbf;
    rd(`GLC_OFS_POLL, v);
    chk("poll byte", v, 9'h040);
    wr(`GLC_OFS_CTRL, 8'h0c);
    rd(`GLC_OFS_STAT, v);
    chk("stat", {parallel_poll_out, v}, 9'h10c);
    rd(4'hc, v);
    chk("unmapped", v, 9'h000);
  endtask
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  initial begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_ifc();
    t_ren();
    t_atn();
    t_tcs();
    t_end();
    t_poll();
    tally_and_finish();
  end
endmodule : glc_line_control_tb_top
`default_nettype wire

/* File: dv/glc_talker_model.sv */
`timescale 1ns/10ps
`default_nettype none
module glc_talker_model (
  // Clock, reset and byte request
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic send_in,
  input wire logic [3:0] hold_in,
  input wire logic eoi_in,
  // Source lines, low active, pulled up when released
  output logic dav_n_out,
  output logic eoi_n_out
);
  logic [3:0] left;
  logic eoi_q;
  // Hold length per byte lets the talker answer fast or slow
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left <= 4'h0;
      eoi_q <= 1'b0;
    end else if (send_in) begin
      left <= hold_in;
      eoi_q <= eoi_in;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign dav_n_out = left == 4'h0;
  assign eoi_n_out = !(eoi_q && left != 4'h0);
endmodule : glc_talker_model
`default_nettype wire

/* File: rtl/glc_line_control.sv */
// Overview of operation
// [R01] Writing one to the clear bit pulses IFC, released after about 150 us.
// [R02] REN follows its bit until cleared, soft reinitialise or reset.
// [R03] Setting the attention bit asserts ATN at once, ignoring handshakes.
// [R04] Take-over waits for a byte cycle, holds NRFD, then sets attention.
// [R05] Attention bit becoming set always clears the take-over bit.
// [R06] Without a completed byte cycle the take-over never sets attention.
// [R07] A pulse marks that bus control was taken, for an interrupt vector.
// [R08] End-seen flag sets on EOI with a byte; software clears it.
// [R09] Controller commands only under ATN; IFC and REN may go anytime.
// [R10] Only the controller in charge leaves idle; one system controller.
// [R11] On a stalled take-over software issues IFC or forced ATN, then DCL.
// [R12] Serial poll: UNL, SPE, address talkers, read bytes, UNT, SPD.
// [R13] Serial poll byte bit 6 on DIO7 reports a service request.
// [R14] Parallel poll configured with PPC then PPE pattern 110SNNN.
// [R15] Parallel poll runs with attention and end-identify set; lines read raw.
// [R16] Control passes by talker address plus TCT, effective on ATN release.
// [R17] Interface commands use the fixed octal code table.
// [R18] End-seen sets when EOI and DAV are asserted with ATN unasserted.
// [R19] Soft reinitialise bit resets the block exactly like the reset.
// [R20] IFC pulse timed by a cycle counter that clears the drive bit.
// [R21] Take-over keeps NRFD asserted until ATN is asserted.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "glc_regs.svh"

module glc_line_control
  import glc_pkg::*;
#(
  parameter logic [`GLC_CNT_W-1:0] IFC_CYCLES = `GLC_IFC_CYCLES
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Register port
  input wire logic [`GLC_ADDR_W-1:0] addr_in,
  input wire logic [`GLC_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`GLC_DATA_W-1:0] rdata_out,
  // Open-drain bus lines driven by this block (low active)
  input wire logic ifc_n_in,
  output logic ifc_n_out,
  output logic ifc_n_oe_out,
  input wire logic ren_n_in,
  output logic ren_n_out,
  output logic ren_n_oe_out,
  input wire logic atn_n_in,
  output logic atn_n_out,
  output logic atn_n_oe_out,
  input wire logic eoi_n_in,
  output logic eoi_n_out,
  output logic eoi_n_oe_out,
  input wire logic nrfd_n_in,
  output logic nrfd_n_out,
  output logic nrfd_n_oe_out,
  // Bus lines only sensed (low active)
  input wire logic dav_n_in,
  input wire logic ndac_n_in,
  input wire logic srq_n_in,
  input wire logic [7:0] dio_n_in,
  // Side signals
  output logic listen_unconditional_out,
  output logic control_taken_out,
  output logic parallel_poll_out
);

  glc_state_t s;
  glc_state_t next_s;

  logic atn_bus;
  logic eoi_bus;
  logic dav_bus;
  logic wr_ctrl;
  logic [`GLC_DATA_W-1:0] ctrl_image;
  logic [`GLC_DATA_W-1:0] stat_image;

  assign atn_bus = ~atn_n_in;
  assign eoi_bus = ~eoi_n_in;
  assign dav_bus = ~dav_n_in;
  assign wr_ctrl = wr_in && (addr_in == `GLC_OFS_CTRL);

  always_comb begin
    ctrl_image = `GLC_RDATA_IDLE;
    ctrl_image[`GLC_CTRL_IFC] = s.iface_clear_drive_bit;
    ctrl_image[`GLC_CTRL_REN] = s.ren_drive;
    ctrl_image[`GLC_CTRL_EOI] = s.end_identify_drive_bit;
    ctrl_image[`GLC_CTRL_ATN] = s.attention_drive_bit;
    ctrl_image[`GLC_CTRL_TCS] = s.tcs;
    ctrl_image[`GLC_CTRL_LISTEN] = s.listen_unconditional_bit;
    stat_image = `GLC_RDATA_IDLE;
    stat_image[`GLC_STAT_END] = s.end_seen_flag;
    stat_image[`GLC_STAT_HOLD] = (s.tcs_state == GLC_TCS_HOLD);
    stat_image[`GLC_STAT_ATN] = atn_bus;
    stat_image[`GLC_STAT_EOI] = eoi_bus;
    stat_image[`GLC_STAT_SRQ] = ~srq_n_in;
    stat_image[`GLC_STAT_REN] = ~ren_n_in;
    stat_image[`GLC_STAT_IFC] = ~ifc_n_in;
    stat_image[`GLC_STAT_DAV] = dav_bus;
  end

  always_comb begin
    next_s = s;
    next_s.taken = 1'b0;
    next_s.rdata = `GLC_RDATA_IDLE;

    // Self-terminating clear pulse
    if (s.iface_clear_drive_bit) begin
      // Count runs down to zero so the line stays driven IFC_CYCLES cycles
      if (s.ifc_count == `GLC_CNT_ZERO) begin
        next_s.iface_clear_drive_bit = 1'b0; // [R20]
        next_s.ifc_count = `GLC_CNT_ZERO;
      end else begin
        next_s.ifc_count = s.ifc_count - `GLC_CNT_ONE; // [R20]
      end
    end

    // Synchronous take-over; stalls forever if no byte cycle comes
    case (s.tcs_state)
      GLC_TCS_IDLE: begin
        if (s.tcs) begin
          next_s.tcs_state = GLC_TCS_WAIT;
        end
      end
      GLC_TCS_WAIT: begin
        if (!s.tcs) begin
          next_s.tcs_state = GLC_TCS_IDLE;
        end else if (dav_bus) begin
          next_s.tcs_state = GLC_TCS_HOLD; // [R04] [R06]
        end
      end
      GLC_TCS_HOLD: begin
        if (!s.tcs) begin
          next_s.tcs_state = GLC_TCS_IDLE;
        end else if (!dav_bus) begin
          // Byte finished; NRFD drops in the cycle ATN rises
          next_s.attention_drive_bit = 1'b1; // [R04] [R21]
          next_s.tcs_state = GLC_TCS_IDLE;
        end
      end
      default: begin
        next_s.tcs_state = GLC_TCS_IDLE;
      end
    endcase

    if (wr_ctrl) begin
      next_s.ren_drive = wdata_in[`GLC_CTRL_REN]; // [R02]
      next_s.end_identify_drive_bit = wdata_in[`GLC_CTRL_EOI]; // [R15]
      next_s.attention_drive_bit = wdata_in[`GLC_CTRL_ATN]; // [R03]
      next_s.tcs = wdata_in[`GLC_CTRL_TCS];
      next_s.listen_unconditional_bit = wdata_in[`GLC_CTRL_LISTEN];
      // Zero write cannot cut a pulse short; a one restarts nothing
      if (wdata_in[`GLC_CTRL_IFC] && !s.iface_clear_drive_bit) begin
        next_s.iface_clear_drive_bit = 1'b1; // [R01]
        next_s.ifc_count = IFC_CYCLES - `GLC_CNT_ONE; // [R20]
      end
      if (wdata_in[`GLC_CTRL_END_CLR]) begin
        next_s.end_seen_flag = 1'b0;
      end
    end

    // Set placed after the clear so a same-cycle END is kept
    if (eoi_bus && dav_bus && !atn_bus) begin
      next_s.end_seen_flag = 1'b1; // [R08] [R18]
    end

    if (next_s.attention_drive_bit) begin
      next_s.tcs = 1'b0; // [R05]
      if (next_s.tcs_state != GLC_TCS_IDLE) begin
        next_s.tcs_state = GLC_TCS_IDLE;
      end
    end
    if (next_s.attention_drive_bit && !s.attention_drive_bit) begin
      next_s.taken = 1'b1; // [R07]
    end

    if (rd_in) begin
      if (addr_in == `GLC_OFS_CTRL) begin
        next_s.rdata = ctrl_image;
      end else if (addr_in == `GLC_OFS_STAT) begin
        next_s.rdata = stat_image;
      end else if (addr_in == `GLC_OFS_POLL) begin
        // Raw lines: serial poll byte or parallel poll answer
        next_s.rdata = ~dio_n_in; // [R13] [R15]
      end else begin
        next_s.rdata = `GLC_RDATA_IDLE;
      end
    end

    if (wr_ctrl && wdata_in[`GLC_CTRL_REINIT]) begin
      next_s = '0; // [R19] [R02]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign ifc_n_out = `GLC_LINE_LOW;
  assign ifc_n_oe_out = s.iface_clear_drive_bit; // [R01]
  assign ren_n_out = `GLC_LINE_LOW;
  assign ren_n_oe_out = s.ren_drive; // [R02]
  assign atn_n_out = `GLC_LINE_LOW;
  assign atn_n_oe_out = s.attention_drive_bit; // [R03]
  assign eoi_n_out = `GLC_LINE_LOW;
  assign eoi_n_oe_out = s.end_identify_drive_bit;
  assign nrfd_n_out = `GLC_LINE_LOW;
  assign nrfd_n_oe_out = (s.tcs_state == GLC_TCS_HOLD); // [R04] [R21]
  assign listen_unconditional_out = s.listen_unconditional_bit;
  assign control_taken_out = s.taken; // [R07]
  assign parallel_poll_out =
    s.attention_drive_bit && s.end_identify_drive_bit; // [R15]

endmodule : glc_line_control
`default_nettype wire

/* File: rtl/glc_pkg.sv */
`include "glc_regs.svh"

package glc_pkg;

  typedef enum logic [1:0] {
    GLC_TCS_IDLE = 2'b00,
    GLC_TCS_WAIT = 2'b01,
    GLC_TCS_HOLD = 2'b10
  } glc_tcs_t;

  typedef struct packed {
    logic [`GLC_CNT_W-1:0] ifc_count;
    logic iface_clear_drive_bit;
    logic ren_drive;
    logic end_identify_drive_bit;
    logic attention_drive_bit;
    logic tcs;
    logic listen_unconditional_bit;
    logic end_seen_flag;
    logic taken;
    glc_tcs_t tcs_state;
    logic [`GLC_DATA_W-1:0] rdata;
  } glc_state_t;

endpackage : glc_pkg

/* File: rtl/glc_regs.svh */
`ifndef GLC_REGS_SVH
`define GLC_REGS_SVH

// Register offsets (byte addresses on the local port)
`define GLC_ADDR_W 4
`define GLC_OFS_CTRL 4'h0
`define GLC_OFS_STAT 4'h4
`define GLC_OFS_POLL 4'h8

// Control register fields
`define GLC_CTRL_IFC 0
`define GLC_CTRL_REN 1
`define GLC_CTRL_EOI 2
`define GLC_CTRL_ATN 3
`define GLC_CTRL_TCS 4
`define GLC_CTRL_LISTEN 5
`define GLC_CTRL_REINIT 6
`define GLC_CTRL_END_CLR 7

// Status register fields
`define GLC_STAT_END 0
`define GLC_STAT_HOLD 1
`define GLC_STAT_ATN 2
`define GLC_STAT_EOI 3
`define GLC_STAT_SRQ 4
`define GLC_STAT_REN 5
`define GLC_STAT_IFC 6
`define GLC_STAT_DAV 7

// Poll register field: service request bit of a serial poll byte
`define GLC_POLL_RQS 6

// Data and reset values
`define GLC_DATA_W 8
`define GLC_RDATA_IDLE 8'h00
`define GLC_LINE_LOW 1'b0

// Interface clear pulse timing
`define GLC_CLK_MHZ 20
`define GLC_IFC_PULSE_US 150
`define GLC_IFC_CYCLES (`GLC_IFC_PULSE_US * `GLC_CLK_MHZ)
`define GLC_CNT_W 12
`define GLC_CNT_ONE 12'h001
`define GLC_CNT_ZERO 12'h000

`endif
